// >>> rtl/cmc_pkg.sv
// Package: register map, field layout and timing for the modulator control
package cmc_pkg;

  // Register indices on the plain 2-bit register port
  localparam logic [1:0] ADDR_CTRL_STATUS = 2'h0;
  localparam logic [1:0] ADDR_PERIOD_HIGH = 2'h1;
  localparam logic [1:0] ADDR_MARK_LOW    = 2'h2;
  localparam logic [1:0] ADDR_SPACE_LOW   = 2'h3;

  // Control/status bit positions
  localparam int BIT_END_OF_CYCLE = 7;
  localparam int BIT_HALF_RATE    = 6;
  localparam int BIT_EXT_MASK     = 5;
  localparam int BIT_EXT_SPACE    = 4;
  localparam int BIT_BASEBAND     = 3;
  localparam int BIT_FSK_MODE     = 2;
  localparam int BIT_CYCLE_IE     = 1;
  localparam int BIT_ENABLE       = 0;

  // Period width and nibble split of the high register
  localparam int PERIOD_W      = 12;
  localparam int MARK_NIB_LSB  = 4;
  localparam int SPACE_NIB_LSB = 0;

  // Reset values
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [11:0] PERIOD_RESET = 12'h000;

  // Time-mode tick: oscillator divided by eight, by sixteen with half rate set
  localparam logic [2:0] TICK_DIV_LAST = 3'h7;

  // Decoded control bits travel together
  typedef struct packed {
    logic half_rate;
    logic ext_mask;
    logic ext_space;
    logic baseband;
    logic fsk_mode;
    logic cycle_ie;
    logic enable;
  } cmc_ctrl_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MARK,
    ST_SPACE
  } cmc_state_e;

endpackage : cmc_pkg

// >>> rtl/cmc_modulator.sv
// Carrier modulator mark/space timer with control and status registers
`timescale 1ns/10ps

module cmc_modulator (
  input  wire logic       CLK_I,
  input  wire logic       RST_B_I,
  input  wire logic       CE_I,
  input  wire logic [1:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  input  wire logic       CARRIER_PERIOD_I,
  input  wire logic       EXT_IRQ_I,
  input  wire logic       KEYSCAN_IRQ_I,
  output logic            CYCLE_IRQ_O,
  output logic            EXT_IRQ_O,
  output logic            CARRIER_ENABLE_O,
  output logic            CARRIER_SECONDARY_O,
  output logic            CARRIER_FORCE_HIGH_O,
  output logic            MOD_GATE_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  cmc_pkg::cmc_ctrl_s     ctrl;
  logic                   end_of_cycle;
  logic                   status_read_armed;
  logic [11:0]            mark_buf;
  logic [11:0]            space_buf;
  logic [11:0]            space_act;
  logic [11:0]            counter;
  logic                   ext_space_act;
  logic                   secondary;
  logic [2:0]             tick_div;
  logic                   half_phase;
  logic [2:0]             pin_s1;
  logic [2:0]             pin_s2;
  logic                   ext_irq_s2;
  logic                   key_irq_s2;
  logic                   carrier_s2;
  logic                   carrier_d;
  logic [7:0]             rdata;
  cmc_pkg::cmc_state_e    state;
  cmc_pkg::cmc_state_e    next_state;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding

  function automatic logic hit(input logic [1:0] a, input logic [1:0] r);
    hit = (a == r);
  endfunction : hit

  wire logic wr_ctrl  = WR_I & hit(ADDR_I, cmc_pkg::ADDR_CTRL_STATUS);
  wire logic wr_high  = WR_I & hit(ADDR_I, cmc_pkg::ADDR_PERIOD_HIGH);
  wire logic wr_mark  = WR_I & hit(ADDR_I, cmc_pkg::ADDR_MARK_LOW);
  wire logic wr_space = WR_I & hit(ADDR_I, cmc_pkg::ADDR_SPACE_LOW);
  wire logic rd_ctrl  = RD_I & hit(ADDR_I, cmc_pkg::ADDR_CTRL_STATUS);
  wire logic acc_low  = (WR_I | RD_I)
                      & (hit(ADDR_I, cmc_pkg::ADDR_MARK_LOW)
                       | hit(ADDR_I, cmc_pkg::ADDR_SPACE_LOW));
  // Any other access in between disarms the clear sequence
  wire logic acc_other = (WR_I | RD_I) & ~acc_low & ~rd_ctrl;

  wire logic [7:0] ctrl_byte = {end_of_cycle, ctrl.half_rate, ctrl.ext_mask,
                                ctrl.ext_space, ctrl.baseband, ctrl.fsk_mode,
                                ctrl.cycle_ie, ctrl.enable};
  wire logic [7:0] high_byte = {mark_buf[11:8], space_buf[11:8]};
  wire logic [7:0] read_mux =
      hit(ADDR_I, cmc_pkg::ADDR_CTRL_STATUS) ? ctrl_byte :
      hit(ADDR_I, cmc_pkg::ADDR_PERIOD_HIGH) ? high_byte :
      hit(ADDR_I, cmc_pkg::ADDR_MARK_LOW)    ? mark_buf[7:0] :
                                               space_buf[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Timebase

  // Divide-by-two prescale: half_phase gates every other clock
  wire logic rate_en = ~ctrl.half_rate | half_phase;
  // Time mode ticks each eighth oscillator clock, each sixteenth with half rate set
  wire logic time_tick = rate_en
                       & (tick_div == cmc_pkg::TICK_DIV_LAST);
  // FREQUENCY_SHIFT_MODE mode ticks on each rising carrier period edge, at half rate only on edges in a half_phase cycle
  wire logic fsk_tick = rate_en & carrier_s2 & ~carrier_d;
  wire logic tick = ctrl.fsk_mode ? fsk_tick : time_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Counter and match

  wire logic in_idle  = (state == cmc_pkg::ST_IDLE);
  wire logic in_mark  = (state == cmc_pkg::ST_MARK);
  wire logic in_space = (state == cmc_pkg::ST_SPACE);

  // The comparator looks at the value the counter steps to, so that an
  // empty space register matches on the very tick that ends the mark
  wire logic [11:0] count_next = counter - 12'h001;
  wire logic [11:0] count_cpl  = ~count_next;
  wire logic        underflow  = (counter == 12'h000);

  // Mark expires on the tick taken at count zero
  wire logic mark_expiry = tick & in_mark & underflow;
  wire logic space_match = (count_cpl == space_act);
  wire logic zero_space  = (space_act == cmc_pkg::PERIOD_RESET);
  wire logic space_end   = tick & in_space & space_match;

  // Zero space skips the space state; the next mark follows directly
  wire logic cycle_end = space_end | (mark_expiry & zero_space);
  wire logic start     = in_idle & ctrl.enable;
  wire logic reload    = cycle_end | start;
  wire logic step      = tick & ~in_idle & ~reload;

  // Carrier swaps setting at each mark expiry in frequency-shift mode
  wire logic swap_carrier = ctrl.fsk_mode & mark_expiry;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    next_state = state;
    unique case (state)
      cmc_pkg::ST_IDLE: begin
        if (start) begin
          next_state = cmc_pkg::ST_MARK;
        end
      end
      cmc_pkg::ST_MARK: begin
        if (cycle_end & ctrl.enable) begin
          next_state = cmc_pkg::ST_MARK;
        end else if (cycle_end) begin
          next_state = cmc_pkg::ST_IDLE;
        end else if (mark_expiry) begin
          next_state = cmc_pkg::ST_SPACE;
        end
      end
      cmc_pkg::ST_SPACE: begin
        // Disable takes hold only once the running cycle expires
        if (cycle_end & ctrl.enable) begin
          next_state = cmc_pkg::ST_MARK;
        end else if (cycle_end) begin
          next_state = cmc_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      state <= cmc_pkg::ST_IDLE;
    end else if (CE_I) begin
      state <= next_state;
    end
  end

  // Extended space keeps the gate shut for whole periods, mark included
  wire logic gate_open = in_mark & ~ext_space_act;

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      ctrl <= cmc_pkg::cmc_ctrl_s'(cmc_pkg::CTRL_RESET[6:0]);
    end else if (CE_I & wr_ctrl) begin
      // Flag bit is read-only; the other bits take the write directly
      ctrl <= cmc_pkg::cmc_ctrl_s'(WDATA_I[6:0]);
    end
  end

  // Single stage: a new mark is picked up at the next reload
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      mark_buf <= cmc_pkg::PERIOD_RESET;
    end else if (CE_I) begin
      if (wr_high) begin
        mark_buf[11:8] <= WDATA_I[7:4];
      end
      if (wr_mark) begin
        mark_buf[7:0] <= WDATA_I;
      end
    end
  end

  // Space buffer feeds the active register at every cycle end
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      space_buf <= cmc_pkg::PERIOD_RESET;
    end else if (CE_I) begin
      if (wr_high) begin
        space_buf[11:8] <= WDATA_I[3:0];
      end
      if (wr_space) begin
        space_buf[7:0] <= WDATA_I;
      end
    end
  end

  // Read data stands for one cycle only, zero otherwise
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      rdata <= 8'h00;
    end else if (CE_I) begin
      rdata <= RD_I ? read_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle-end flag

  // Hardware set wins over the software clear sequence
  wire logic flag_clear = status_read_armed & acc_low;

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      end_of_cycle <= 1'b0;
    end else if (CE_I) begin
      if (cycle_end) begin
        end_of_cycle <= 1'b1;
      end else if (flag_clear) begin
        end_of_cycle <= 1'b0;
      end
    end
  end

  // A status read arms the clear; the next access decides
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      status_read_armed <= 1'b0;
    end else if (CE_I) begin
      if (rd_ctrl) begin
        status_read_armed <= 1'b1;
      end else if (acc_low | acc_other) begin
        status_read_armed <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modulator datapath

  // Prescale phase and the divide-by-eight tick counter
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      half_phase <= 1'b0;
      tick_div   <= 3'h0;
    end else if (CE_I) begin
      half_phase <= ~half_phase;
      if (rate_en) begin
        tick_div <= tick_div + 3'h1;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      counter <= cmc_pkg::PERIOD_RESET;
    end else if (CE_I) begin
      if (reload) begin
        counter <= mark_buf;
      end else if (step) begin
        counter <= count_next;
      end
    end
  end

  // Both latch at every reload, whatever the flag holds
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      space_act     <= cmc_pkg::PERIOD_RESET;
      ext_space_act <= 1'b0;
    end else if (CE_I & reload) begin
      space_act     <= space_buf;
      ext_space_act <= ctrl.ext_space;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      secondary <= 1'b0;
    end else if (CE_I) begin
      if (start) begin
        secondary <= 1'b0;
      end else if (swap_carrier) begin
        secondary <= ~secondary;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Bit 0 external request, bit 1 keyscan, bit 2 carrier period
  wire logic [2:0] pin_raw = {CARRIER_PERIOD_I, KEYSCAN_IRQ_I, EXT_IRQ_I};

  // Only the second stage is read, so a metastable first stage stays local
  for (genvar g = 0; g < 3; g++) begin : g_sync
    always_ff @(posedge CLK_I) begin
      if (!RST_B_I) begin
        pin_s1[g] <= 1'b0;
        pin_s2[g] <= 1'b0;
      end else if (CE_I) begin
        pin_s1[g] <= pin_raw[g];
        pin_s2[g] <= pin_s1[g];
      end
    end
  end

  assign ext_irq_s2 = pin_s2[0];
  assign key_irq_s2 = pin_s2[1];
  assign carrier_s2 = pin_s2[2];

  // Delayed copy for the carrier edge detector; idles low like the pin
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      carrier_d <= 1'b0;
    end else if (CE_I) begin
      carrier_d <= carrier_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign RDATA_O              = rdata;
  assign CYCLE_IRQ_O          = end_of_cycle & ctrl.cycle_ie;
  assign EXT_IRQ_O            = (ext_irq_s2 | key_irq_s2)
                              & ~ctrl.ext_mask;
  assign CARRIER_ENABLE_O     = (state != cmc_pkg::ST_IDLE)
                              & ~ctrl.baseband;
  assign CARRIER_FORCE_HIGH_O = ctrl.baseband;
  assign CARRIER_SECONDARY_O  = secondary;
  assign MOD_GATE_O           = gate_open;

endmodule : cmc_modulator

// >>> verification/cmc_carrier_model.sv
// Carrier generator stand-in that feeds carrier periods back to the block
`timescale 1ns/10ps
module cmc_carrier_model (
  input  wire logic CLK_I,
  input  wire logic enable_i,
  input  wire logic secondary_i,
  output logic      carrier_o
);
  logic [2:0] cnt;
  // Stands still while disabled; secondary setting gives a shorter period
  initial carrier_o = 1'b0;
  always @(posedge CLK_I) begin
    if (!enable_i) begin
      cnt <= 3'h0;
      carrier_o <= 1'b0;
    end else if (cnt >= (secondary_i ? 3'h1 : 3'h2)) begin
      cnt <= 3'h0;
      carrier_o <= !carrier_o;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end
endmodule : cmc_carrier_model

// >>> verification/cmc_modulator_checker.sv
// Port-level assertions for the modulator control block
`timescale 1ns/10ps
module cmc_modulator_checker (
  input wire logic       CLK_I,
  input wire logic       RST_B_I,
  input wire logic       CE_I,
  input wire logic [1:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic       WR_I,
  input wire logic       RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic       CARRIER_PERIOD_I,
  input wire logic       EXT_IRQ_I,
  input wire logic       KEYSCAN_IRQ_I,
  input wire logic       CYCLE_IRQ_O,
  input wire logic       EXT_IRQ_O,
  input wire logic       CARRIER_ENABLE_O,
  input wire logic       CARRIER_SECONDARY_O,
  input wire logic       CARRIER_FORCE_HIGH_O,
  input wire logic       MOD_GATE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  wire ext_req = EXT_IRQ_I | KEYSCAN_IRQ_I;
  sequence s_status_read;
    CE_I && RD_I && ADDR_I == cmc_pkg::ADDR_CTRL_STATUS;
  endsequence
  sequence s_low_access;
    CE_I && (RD_I || WR_I) && ADDR_I[1];
  endsequence
  sequence s_bus_idle;
    !(CE_I && (RD_I || WR_I));
  endsequence
  a_read_stands: assert property ($past(CE_I) && !$past(RD_I) |->
    RDATA_O == 8'h00) else $error("read data outside its cycle");
  a_irq_matches: assert property (s_status_read |=>
    (RDATA_O[7] && RDATA_O[1]) == $past(CYCLE_IRQ_O))
    else $error("cycle request differs from flag and enable");
  a_force_high: assert property (s_status_read |=>
    RDATA_O[3] == $past(CARRIER_FORCE_HIGH_O))
    else $error("force high differs from baseband bit");
  a_ext_masked: assert property (s_status_read |=>
    !(RDATA_O[5] && $past(EXT_IRQ_O))) else $error("masked request passed");
  a_ext_passes: assert property ($rose(EXT_IRQ_O) |->
    $past(ext_req, 2) || $past(ext_req, 3))
    else $error("external request without cause");
  a_carrier_baseband_select: assert property (CARRIER_ENABLE_O |->
    !CARRIER_FORCE_HIGH_O) else $error("carrier runs in baseband");
  a_gate_running: assert property (MOD_GATE_O && !CARRIER_FORCE_HIGH_O
    |-> CARRIER_ENABLE_O) else $error("gate open with carrier stopped");
  a_flag_clear: assert property (s_status_read ##1 s_low_access |=>
    !CYCLE_IRQ_O || $rose(MOD_GATE_O)) else $error("flag not cleared");
  a_flag_gap: assert property (s_status_read ##1 s_bus_idle
    ##1 s_low_access |=> !CYCLE_IRQ_O || $rose(MOD_GATE_O))
    else $error("flag not cleared after idle cycle");
  a_reset_quiet: assert property ($rose(RST_B_I) |-> !MOD_GATE_O
    && !CYCLE_IRQ_O && !CARRIER_ENABLE_O) else $error("active after reset");
endmodule : cmc_modulator_checker
bind cmc_modulator cmc_modulator_checker cmc_modulator_checker_inst (.*);

// >>> verification/test_cmc_modulator.sv
// Register and timing scenarios for the modulator control block
`timescale 1ns/10ps
module test_cmc_modulator;
  logic       CLK_I = 1'b0, RST_B_I = 1'b0, WR_I = 1'b0, RD_I = 1'b0;
  logic       EXT_IRQ_I = 1'b0, KEYSCAN_IRQ_I = 1'b0, CARRIER_PERIOD_I;
  logic [1:0] ADDR_I = 2'h0;
  logic [7:0] WDATA_I = 8'h00, RDATA_O;
  logic       CYCLE_IRQ_O, EXT_IRQ_O, CARRIER_ENABLE_O, MOD_GATE_O;
  logic       CARRIER_SECONDARY_O, CARRIER_FORCE_HIGH_O;
  logic       CE_I = 1'b1, sec;
  int         fails = 0, samples_checked = 0, cycles = 0, hi, lo;
  cmc_modulator cmc_modulator_inst (.CLK_I, .RST_B_I, .CE_I,
    .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .CARRIER_PERIOD_I,
    .EXT_IRQ_I, .KEYSCAN_IRQ_I, .CYCLE_IRQ_O, .EXT_IRQ_O, .MOD_GATE_O,
    .CARRIER_ENABLE_O, .CARRIER_SECONDARY_O, .CARRIER_FORCE_HIGH_O);
  cmc_carrier_model cmc_carrier_model_inst (.CLK_I,
    .enable_i(CARRIER_ENABLE_O), .secondary_i(CARRIER_SECONDARY_O),
    .carrier_o(CARRIER_PERIOD_I));
  initial forever #5 CLK_I = ~CLK_I;
  always @(posedge CLK_I) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end
  task chk(input string what, input logic [11:0] exp, got);
    samples_checked++;
    if (exp !== got) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : chk
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge CLK_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge CLK_I);
    WR_I <= 1'b0;
  endtask : wr
  task rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge CLK_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge CLK_I);
    RD_I <= 1'b0;
    @(negedge CLK_I);
    chk("read data", {4'h0, exp}, {4'h0, RDATA_O});
  endtask : rd
  // Counts cycles at one gate level; the cap doubles as a hang guard
  task run(input logic lvl, output int n);
    n = 0;
    while (MOD_GATE_O === lvl && n < 3000) begin
      @(negedge CLK_I);
      n++;
    end
  endtask : run
  // Skips the cycle in progress so only whole periods are measured
  task period();
    run(1'b1, hi);
    run(1'b0, lo);
    run(1'b1, hi);
    run(1'b0, lo);
  endtask : period
  task finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  initial begin
    repeat (8) @(posedge CLK_I);
    RST_B_I <= 1'b1;
    for (int a = 0; a < 4; a++) rd(2'(a), 8'h00);
    $display("test reset values done");
    wr(0, 8'hfe);
    rd(0, 8'h7e);
    wr(1, 8'ha5);
    rd(1, 8'ha5);
    wr(2, 8'h3c);
    rd(2, 8'h3c);
    @(posedge CLK_I);
    CE_I <= 1'b0;
    wr(2, 8'hff);
    CE_I <= 1'b1;
    rd(2, 8'h3c);
    wr(3, 8'hc3);
    rd(3, 8'hc3);
    wr(1, 8'h00);
    EXT_IRQ_I <= 1'b1;
    repeat (5) @(negedge CLK_I);
    chk("ext masked", 12'h000, {11'h0, EXT_IRQ_O});
    wr(0, 8'h00);
    repeat (5) @(negedge CLK_I);
    chk("ext open", 12'h001, {11'h0, EXT_IRQ_O});
    @(posedge CLK_I);
    EXT_IRQ_I <= 1'b0;
    KEYSCAN_IRQ_I <= 1'b1;
    repeat (6) @(negedge CLK_I);
    chk("keyscan open", 12'h001, {11'h0, EXT_IRQ_O});
    @(posedge CLK_I);
    KEYSCAN_IRQ_I <= 1'b0;
    $display("test register map done");
    wr(2, 8'h02);
    wr(3, 8'h03);
    wr(0, 8'h03);
    period();
    chk("mark", 12'h018, 12'(hi));
    chk("space", 12'h018, 12'(lo));
    chk("cycle irq", 12'h001, {11'h0, CYCLE_IRQ_O});
    rd(0, 8'h83);
    wr(2, 8'h05);
    @(negedge CLK_I);
    chk("irq cleared", 12'h000, {11'h0, CYCLE_IRQ_O});
    wr(3, 8'h01);
    period();
    chk("new mark", 12'h030, 12'(hi));
    chk("new space", 12'h008, 12'(lo));
    wr(0, 8'h43);
    period();
    chk("half mark", 12'h060, 12'(hi));
    chk("half space", 12'h010, 12'(lo));
    $display("test timing done");
    wr(0, 8'h40);
    run(1'b1, hi);
    run(1'b0, lo);
    chk("stopped", 12'hbb8, 12'(lo));
    chk("no irq", 12'h000, {11'h0, CYCLE_IRQ_O});
    rd(0, 8'hc0);
    wr(0, 8'h05);
    period();
    sec = CARRIER_SECONDARY_O;
    run(1'b1, hi);
    run(1'b0, lo);
    chk("carrier swap", {11'h0, ~sec}, {11'h0, CARRIER_SECONDARY_O});
    wr(0, 8'h04);
    repeat (100) @(negedge CLK_I);
    chk("fsk stopped", 12'h000, {11'h0, CARRIER_ENABLE_O});
    wr(0, 8'h09);
    @(negedge CLK_I);
    chk("force high", 12'h001, {11'h0, CARRIER_FORCE_HIGH_O});
    chk("carrier off", 12'h000, {11'h0, CARRIER_ENABLE_O});
    wr(0, 8'h19);
    run(1'b1, hi);
    run(1'b0, lo);
    chk("ext space", 12'hbb8, 12'(lo));
    wr(0, 8'h00);
    $display("test stop and extended space done");
    finish_test();
  end
endmodule : test_cmc_modulator
